// ===== shared/endpoint_irq_pkg.sv
// Constants shared by the endpoint transaction-done interrupt block.
package endpoint_irq_pkg;
    // Endpoint counts and bus widths.
    localparam int EP_COUNT = 8;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int INDEX_W = 16;
    localparam int CODE_W = 6;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_VECTOR = 16'hffb2;
    localparam logic [15:0] IDX_IN_STATUS = 16'hffb3;
    localparam logic [15:0] IDX_OUT_STATUS = 16'hffb4;
    localparam logic [15:0] IDX_OUT_ISO = 16'hffc0;
    localparam logic [15:0] IDX_IN_ISO = 16'hffc1;
    localparam logic [15:0] IDX_EVT_STATUS = 16'hffc2;
    localparam logic [15:0] IDX_EVT_ENABLE = 16'hffc3;
    localparam logic [15:0] IDX_EVT_CLEAR = 16'hffc4;

    // Vector codes.
    localparam logic [5:0] CODE_OUT_BASE = 6'h00;
    localparam logic [5:0] CODE_IN_BASE = 6'h08;
    localparam logic [5:0] CODE_NONE = 6'h24;

    // Values after reset.
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ISO_RESET = 8'h00;
    localparam logic [31:0] READDATA_RESET = 32'h0000_0000;
    localparam logic [3:0] EVT_RESET = 4'h0;

    // Event register layout.
    localparam int EVT_COUNT = 4;
    localparam int EVT_OUT_DONE = 0;
    localparam int EVT_IN_DONE = 1;
    localparam int EVT_ISO_DROP = 2;
    localparam int EVT_VEC_ACK = 3;

    // Bus answer sequencing.
    typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage

// ===== design/vector_priority_encoder.sv
// Fixed-priority encoder that turns endpoint pending bits into a vector code.
`timescale 1ns/100ps
module vector_priority_encoder
    import endpoint_irq_pkg::*;
(
    // Pending bits.
    input wire logic [7:0] out_pend,
    input wire logic [7:0] in_pend,
    // Selected code.
    output logic [5:0] code
);

    // Lowest priority is written first so that each later match overrides it.
    // Endpoint zero is checked last because the control pipe must win.
    always_comb begin
        code = CODE_NONE;
        for (int i = 1; i < EP_COUNT; i++) begin
            if (out_pend[i]) begin
                code = CODE_OUT_BASE + 6'(i);
            end
        end
        for (int i = 1; i < EP_COUNT; i++) begin
            if (in_pend[i]) begin
                code = CODE_IN_BASE + 6'(i);
            end
        end
        if (in_pend[0]) begin
            code = CODE_IN_BASE;
        end
        if (out_pend[0]) begin
            code = CODE_OUT_BASE;
        end
    end

endmodule

// ===== design/event_status_block.sv
// Sticky event status with enable mask, write-one clear and one level interrupt.
`timescale 1ns/100ps
module event_status_block
    import endpoint_irq_pkg::*;
#(
    parameter int N = 4
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Event pulses from the block.
    input wire logic [N-1:0] evt_pulse,
    // Register writes.
    input wire logic enable_wr,
    input wire logic [N-1:0] enable_data,
    input wire logic clear_wr,
    input wire logic [N-1:0] clear_data,
    // State.
    output logic [N-1:0] status,
    output logic [N-1:0] enable,
    output logic irq
);

    // Each bit is sticky; an event in the clearing cycle beats the clear so none is lost.
    for (genvar g = 0; g < N; g++) begin : g_bit
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                status[g] <= 1'b0;
            end else begin
                status[g] <= evt_pulse[g] | (status[g] & ~(clear_wr & clear_data[g]));
            end
        end
    end

    // Enable mask written by software.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable <= N'(EVT_RESET);
        end else if (enable_wr) begin
            enable <= enable_data;
        end
    end

    // Level interrupt while any enabled bit is set.
    assign irq = |(status & enable);

    property p_evt_set_wins;
        @(posedge clk) disable iff (!rst_b)
        (evt_pulse != '0) |=> ((status & $past(evt_pulse)) == $past(evt_pulse));
    endproperty
    a_evt_set_wins: assert property (p_evt_set_wins)
        else $error("Event pulse did not set its sticky bit.");

endmodule

// ===== design/endpoint_interrupt_status.sv
// Endpoint transaction-done pending bits, vector presentation and register slave.
//
// Contract
// - A successful OUT transaction on endpoint n sets OUT pending bit n.
// - A successful IN transaction on endpoint n sets IN pending bit n.
// - Any pending bit raises the processor interrupt and presents that endpoint's vector.
// - Writing the vector register clears the presented pending bit; writing status registers does nothing.
// - Isochronous endpoints never set pending bits nor raise this interrupt.
// - Both status registers are read-only; reading them changes nothing.
// - OUT status sits at index ffb4, IN status at ffb3, both reset zero.
// - Codes 00h-07h are OUT endpoints, 08h-0fh IN endpoints, 24h means idle.
// - Software acknowledges by writing any value; the next pending vector then shows.
// - Higher codes win, except endpoint zero which wins over all.
`timescale 1ns/100ps
module endpoint_interrupt_status
    import endpoint_irq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Transaction-done pulses from the usb buffer manager.
    input wire logic [7:0] out_done,
    input wire logic [7:0] in_done,
    // Processor side.
    output logic processor_interrupt_line,
    output logic [5:0] vector_code_field,
    output logic irq
);

    // Register state.
    logic [7:0] out_done_pending_bits;
    logic [7:0] in_done_pending_bits;
    logic [7:0] out_iso;
    logic [7:0] in_iso;
    logic [5:0] vector_code;
    logic [3:0] evt_status;
    logic [3:0] evt_enable;

    // Combinational helpers.
    logic [7:0] out_set;
    logic [7:0] in_set;
    logic [7:0] clr_out;
    logic [7:0] clr_in;
    logic [7:0] next_out_pending;
    logic [7:0] next_in_pending;
    logic [5:0] next_vector;
    logic [3:0] evt_pulse;
    logic [15:0] idx;
    logic [31:0] rd_value;
    logic wr_fire;
    logic rd_fire;
    logic vec_ack;
    logic wr_low_lane;
    bus_state_e bus_state;

    // Registers sit on aligned words; the two low address bits are ignored.
    assign idx = address[17:2];

    // Every access is answered on the second cycle; the first samples read data.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (read || write) begin
                        bus_state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // Wait is held only during the first cycle of a request.
    assign waitrequest = (read || write) && (bus_state != BUS_ANSWER);
    assign wr_fire = write && (bus_state == BUS_ANSWER);
    assign rd_fire = read && (bus_state == BUS_ANSWER);
    assign wr_low_lane = wr_fire && byteenable[0];

    // The acknowledge ignores the data and byte lanes: any write counts.
    assign vec_ack = wr_fire && (idx == IDX_VECTOR);

    // Read mux; unmapped and write-only locations read as zero.
    always_comb begin
        rd_value = 32'h0000_0000;
        case (idx)
            IDX_VECTOR: rd_value = {26'h0, vector_code};
            IDX_IN_STATUS: rd_value = {24'h0, in_done_pending_bits};
            IDX_OUT_STATUS: rd_value = {24'h0, out_done_pending_bits};
            IDX_OUT_ISO: rd_value = {24'h0, out_iso};
            IDX_IN_ISO: rd_value = {24'h0, in_iso};
            IDX_EVT_STATUS: rd_value = {28'h0, evt_status};
            IDX_EVT_ENABLE: rd_value = {28'h0, evt_enable};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // Read data are captured in the wait cycle and stand through the answer cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            readdata <= READDATA_RESET;
        end else if (bus_state == BUS_IDLE && read) begin
            readdata <= rd_value;
        end
    end

    // Isochronous flags; they gate the done pulses so those pipes stay silent.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_iso <= ISO_RESET;
            in_iso <= ISO_RESET;
        end else if (wr_low_lane) begin
            if (idx == IDX_OUT_ISO) begin
                out_iso <= writedata[7:0];
            end
            if (idx == IDX_IN_ISO) begin
                in_iso <= writedata[7:0];
            end
        end
    end

    // Per endpoint set and clear terms. The clear is decoded from the code the
    // processor was shown, so a bit that rose later is not lost by the write.
    for (genvar g = 0; g < EP_COUNT; g++) begin : g_ep
        assign out_set[g] = out_done[g] & ~out_iso[g];
        assign in_set[g] = in_done[g] & ~in_iso[g];
        assign clr_out[g] = vec_ack && (vector_code == CODE_OUT_BASE + 6'(g));
        assign clr_in[g] = vec_ack && (vector_code == CODE_IN_BASE + 6'(g));
        // A set in the acknowledge cycle wins over the clear.
        assign next_out_pending[g] = out_set[g] | (out_done_pending_bits[g] & ~clr_out[g]);
        assign next_in_pending[g] = in_set[g] | (in_done_pending_bits[g] & ~clr_in[g]);
    end

    // Pending bits; status register writes are not decoded here at all.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_done_pending_bits <= STATUS_RESET;
            in_done_pending_bits <= STATUS_RESET;
        end else begin
            out_done_pending_bits <= next_out_pending;
            in_done_pending_bits <= next_in_pending;
        end
    end

    // Priority selection on the next pending state keeps the code in step with the bits.
    vector_priority_encoder u_encoder (
        .out_pend(next_out_pending),
        .in_pend(next_in_pending),
        .code(next_vector)
    );

    // Presented vector register; shows the idle code from reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vector_code <= CODE_NONE;
        end else begin
            vector_code <= next_vector;
        end
    end

    // Processor outputs.
    assign vector_code_field = vector_code;
    assign processor_interrupt_line = |{out_done_pending_bits, in_done_pending_bits};

    // Events for the maskable summary interrupt.
    assign evt_pulse[EVT_OUT_DONE] = |out_set;
    assign evt_pulse[EVT_IN_DONE] = |in_set;
    assign evt_pulse[EVT_ISO_DROP] = |((out_done & out_iso) | (in_done & in_iso));
    assign evt_pulse[EVT_VEC_ACK] = vec_ack;

    event_status_block #(
        .N(EVT_COUNT)
    ) u_events (
        .clk(clk),
        .rst_b(rst_b),
        .evt_pulse(evt_pulse),
        .enable_wr(wr_low_lane && (idx == IDX_EVT_ENABLE)),
        .enable_data(writedata[3:0]),
        .clear_wr(wr_low_lane && (idx == IDX_EVT_CLEAR)),
        .clear_data(writedata[3:0]),
        .status(evt_status),
        .enable(evt_enable),
        .irq(irq)
    );

    // Checks on the pending, vector and bus logic.

    property p_out_set;
        @(posedge clk) disable iff (!rst_b)
        (out_set != 8'h00) |=> ((out_done_pending_bits & $past(out_set)) == $past(out_set));
    endproperty
    a_out_set: assert property (p_out_set)
        else $error("OUT done pulse did not set its pending bit.");

    property p_in_set;
        @(posedge clk) disable iff (!rst_b)
        (in_set != 8'h00) |=> ((in_done_pending_bits & $past(in_set)) == $past(in_set));
    endproperty
    a_in_set: assert property (p_in_set)
        else $error("IN done pulse did not set its pending bit.");

    property p_line_and_vector;
        @(posedge clk) disable iff (!rst_b)
        (|{out_done_pending_bits, in_done_pending_bits})
            |-> (processor_interrupt_line && vector_code != CODE_NONE && vector_code < 6'h10);
    endproperty
    a_line_and_vector: assert property (p_line_and_vector)
        else $error("Pending bit without interrupt line or endpoint vector.");

    property p_status_write_void;
        @(posedge clk) disable iff (!rst_b)
        (wr_fire && (idx == IDX_OUT_STATUS || idx == IDX_IN_STATUS)
            && out_set == 8'h00 && in_set == 8'h00)
            |=> $stable(out_done_pending_bits) && $stable(in_done_pending_bits);
    endproperty
    a_status_write_void: assert property (p_status_write_void)
        else $error("Write to a status register changed pending bits.");

    property p_iso_silent;
        @(posedge clk) disable iff (!rst_b)
        ##1 (((out_done_pending_bits & ~$past(out_done_pending_bits)) & $past(out_iso)) == 8'h00)
            && (((in_done_pending_bits & ~$past(in_done_pending_bits)) & $past(in_iso)) == 8'h00);
    endproperty
    a_iso_silent: assert property (p_iso_silent)
        else $error("Isochronous endpoint raised a pending bit.");

    property p_read_void;
        @(posedge clk) disable iff (!rst_b)
        (rd_fire && out_set == 8'h00 && in_set == 8'h00)
            |=> $stable(out_done_pending_bits) && $stable(in_done_pending_bits);
    endproperty
    a_read_void: assert property (p_read_void)
        else $error("Register read changed pending bits.");

    property p_reset_zero;
        @(posedge clk)
        !rst_b |=> (out_done_pending_bits == 8'h00 && in_done_pending_bits == 8'h00
            && vector_code == CODE_NONE);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Pending bits or vector not at reset value.");

    property p_idle_code;
        @(posedge clk) disable iff (!rst_b)
        (out_done_pending_bits == 8'h00 && in_done_pending_bits == 8'h00)
            |-> (vector_code == CODE_NONE && !processor_interrupt_line);
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("Idle vector code not shown with nothing pending.");

    property p_ack_clears;
        @(posedge clk) disable iff (!rst_b)
        ((clr_out | clr_in) != 8'h00)
            |=> (((out_done_pending_bits & $past(clr_out) & ~$past(out_set)) == 8'h00)
            && ((in_done_pending_bits & $past(clr_in) & ~$past(in_set)) == 8'h00));
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("Acknowledge did not clear the presented source.");

    property p_top_priority;
        @(posedge clk) disable iff (!rst_b)
        (out_done_pending_bits[0] |-> vector_code == CODE_OUT_BASE)
            and ((in_done_pending_bits[0] && !out_done_pending_bits[0])
            |-> vector_code == CODE_IN_BASE)
            and ((in_done_pending_bits[7] && !out_done_pending_bits[0]
            && !in_done_pending_bits[0]) |-> vector_code == 6'h0f);
    endproperty
    a_top_priority: assert property (p_top_priority)
        else $error("Vector code does not follow the fixed priority.");

    property p_only_presented;
        @(posedge clk) disable iff (!rst_b)
        ##1 (($past(out_done_pending_bits) & ~$past(clr_out) & ~out_done_pending_bits) == 8'h00)
            && (($past(in_done_pending_bits) & ~$past(clr_in) & ~in_done_pending_bits) == 8'h00);
    endproperty
    a_only_presented: assert property (p_only_presented)
        else $error("A pending bit cleared without its own acknowledge.");

    property p_bus_answer;
        @(posedge clk) disable iff (!rst_b)
        ((read || write) && bus_state == BUS_IDLE) |=> !waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus request not answered in the second cycle.");

    // Main scenarios.
    c_ack_with_more: cover property (@(posedge clk) disable iff (!rst_b)
        vec_ack && $countones({out_done_pending_bits, in_done_pending_bits}) > 1);
    c_iso_drop: cover property (@(posedge clk) disable iff (!rst_b)
        evt_pulse[EVT_ISO_DROP]);
    c_set_on_clear: cover property (@(posedge clk) disable iff (!rst_b)
        ((clr_out & out_set) != 8'h00));
    c_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);

endmodule

// ===== verif/usb_done_source.sv
// Behavioural usb buffer manager that reports finished transactions as pulses.
`timescale 1ns/100ps
module usb_done_source (
    // Clock.
    input wire logic clk,
    // Completion pulses towards the block.
    output logic [7:0] out_done,
    output logic [7:0] in_done
);
    // Quiet from time zero, so the block never sees a stray completion.
    initial begin
        out_done = 8'h00;
        in_done = 8'h00;
    end

    // One-cycle pulse per finished endpoint, launched just after a rising edge.
    task automatic report(input logic [7:0] out_mask, input logic [7:0] in_mask);
        @(posedge clk);
        out_done <= out_mask;
        in_done <= in_mask;
        @(posedge clk);
        out_done <= 8'h00;
        in_done <= 8'h00;
    endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the endpoint transaction-done interrupt block.
`timescale 1ns/100ps
module tb
    import endpoint_irq_pkg::*;
;
    logic clk;
    logic rst_b;
    logic [17:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] out_done;
    logic [7:0] in_done;
    logic processor_interrupt_line;
    logic [5:0] vector_code_field;
    logic irq;
    int n_mismatch = 0;
    int tests_run = 0;

    // Block under test and the buffer manager model that feeds it.
    endpoint_interrupt_status endpoint_interrupt_status_inst (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .out_done(out_done), .in_done(in_done),
        .processor_interrupt_line(processor_interrupt_line),
        .vector_code_field(vector_code_field), .irq(irq)
    );
    usb_done_source usb_done_source_inst (.clk(clk), .out_done(out_done), .in_done(in_done));

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts every comparison and reports each mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access. The request is held until the rising edge at which waitrequest
    // is seen low; read data are taken at that same edge, before the edge's updates land.
    task automatic bus_access(input logic [15:0] idx, input logic wr,
                              input logic [31:0] wdata, output logic [31:0] rdata);
        logic w;
        int n_wait;
        n_wait = 0;
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= wdata;
        do begin
            @(posedge clk);
            w = waitrequest;
            if (w !== 1'b0) begin
                n_wait++;
            end
        end while (w !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // The slave inserts exactly one wait cycle per access.
        check(32'(n_wait), 32'h1);
    endtask

    // Register write and checked register read.
    task automatic reg_wr(input logic [15:0] idx, input logic [31:0] data);
        logic [31:0] d;
        bus_access(idx, 1'b1, data, d);
    endtask
    task automatic reg_rd_check(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus_access(idx, 1'b0, 32'h0000_0000, d);
        check(d, exp);
    endtask

    // Values straight after reset, and an unmapped read.
    task automatic t_reset_values;
        @(negedge clk);
        check({26'h0, vector_code_field}, 32'h24);
        check({31'h0, processor_interrupt_line}, 32'h0);
        reg_rd_check(IDX_IN_STATUS, 32'h0);
        reg_rd_check(IDX_OUT_STATUS, 32'h0);
        reg_rd_check(16'h0100, 32'h0);
    endtask

    // Every endpoint alone: its bit, its code, then acknowledge back to idle.
    task automatic t_each_endpoint;
        for (int k = 0; k < 16; k++) begin
            logic [7:0] m;
            m = 8'h01 << (k % 8);
            usb_done_source_inst.report(k < 8 ? m : 8'h00, k < 8 ? 8'h00 : m);
            @(negedge clk);
            check({26'h0, vector_code_field}, 32'(k));
            check({31'h0, processor_interrupt_line}, 32'h1);
            reg_rd_check(k < 8 ? IDX_OUT_STATUS : IDX_IN_STATUS, {24'h0, m});
            reg_wr(IDX_VECTOR, 32'h0000_0000);
            @(negedge clk);
            check({26'h0, vector_code_field}, 32'h24);
            check({31'h0, processor_interrupt_line}, 32'h0);
        end
    endtask

    // All sixteen pending together; the acknowledges walk the fixed priority.
    task automatic t_priority;
        logic [5:0] order [16];
        order[0] = 6'h00;
        order[1] = 6'h08;
        for (int i = 0; i < 7; i++) begin
            order[2 + i] = 6'(15 - i);
            order[9 + i] = 6'(7 - i);
        end
        usb_done_source_inst.report(8'hff, 8'hff);
        @(negedge clk);
        reg_rd_check(IDX_OUT_STATUS, 32'hff);
        reg_rd_check(IDX_OUT_STATUS, 32'hff);
        reg_wr(IDX_OUT_STATUS, 32'h0000_0000);
        reg_wr(IDX_IN_STATUS, 32'h0000_0000);
        reg_rd_check(IDX_IN_STATUS, 32'hff);
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            check({26'h0, vector_code_field}, {26'h0, order[i]});
            reg_wr(IDX_VECTOR, 32'h0000_005a);
            if (i == 0) begin
                reg_rd_check(IDX_OUT_STATUS, 32'hfe);
                reg_rd_check(IDX_IN_STATUS, 32'hff);
            end
        end
        @(negedge clk);
        check({26'h0, vector_code_field}, 32'h24);
        check({31'h0, processor_interrupt_line}, 32'h0);
    endtask

    // Isochronous endpoints are dropped; a plain neighbour still interrupts.
    task automatic t_iso;
        reg_wr(IDX_OUT_ISO, 32'h04);
        reg_wr(IDX_IN_ISO, 32'h10);
        reg_wr(IDX_EVT_CLEAR, 32'h0f);
        usb_done_source_inst.report(8'h04, 8'h10);
        @(negedge clk);
        check({31'h0, processor_interrupt_line}, 32'h0);
        check({26'h0, vector_code_field}, 32'h24);
        reg_rd_check(IDX_OUT_STATUS, 32'h0);
        reg_rd_check(IDX_IN_STATUS, 32'h0);
        reg_rd_check(IDX_EVT_STATUS, 32'h4);
        usb_done_source_inst.report(8'h08, 8'h00);
        @(negedge clk);
        check({26'h0, vector_code_field}, 32'h03);
        reg_wr(IDX_VECTOR, 32'h0000_0000);
        reg_wr(IDX_OUT_ISO, 32'h00);
        reg_wr(IDX_IN_ISO, 32'h00);
    endtask

    // Event interrupt: raised, masked, enabled and cleared through its registers.
    task automatic t_events;
        reg_wr(IDX_EVT_CLEAR, 32'h0f);
        reg_wr(IDX_EVT_ENABLE, 32'h00);
        usb_done_source_inst.report(8'h02, 8'h00);
        reg_wr(IDX_VECTOR, 32'h0000_0000);
        reg_rd_check(IDX_EVT_STATUS, 32'h9);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        reg_wr(IDX_EVT_ENABLE, 32'h08);
        reg_rd_check(IDX_EVT_ENABLE, 32'h8);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        reg_wr(IDX_EVT_CLEAR, 32'h08);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        reg_rd_check(IDX_EVT_STATUS, 32'h1);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence: reset for five cycles, then the scenarios in turn.
    initial begin
        rst_b = 1'b0;
        address = 18'h00000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values;
        t_each_endpoint;
        t_priority;
        t_iso;
        t_events;
        test_done;
    end

    // Watchdog; the scenarios need well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
endmodule
